// ---- hw/tmc_commit.sv ----
// Commit timer for the configuration byte
// Assumes commit_go pulses once per accepted write
`timescale 1ns/1ps
`default_nettype none
`include "tmc_map.svh"

module tmc_commit #(
  parameter int COMMIT_CYCLES = `TMC_COMMIT_TIME_MS * (`TMC_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Control link
  tmc_ctl_if.commit   ctl
);

  localparam int CW = $clog2(COMMIT_CYCLES + 1);

  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
    logic          done;
  } tmc_cmt_state_t;

  tmc_cmt_state_t s_ff;
  tmc_cmt_state_t nxt_s;

  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    if (ctl.commit_go)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt  = '0;
    end
    else if (s_ff.busy)
    begin
      // Trimmed so pending spans COMMIT_CYCLES, never longer
      if (s_ff.cnt == CW'(COMMIT_CYCLES - 3))
      begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
      else
        nxt_s.cnt = s_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign ctl.commit_done = s_ff.done;

endmodule // tmc_commit

`default_nettype wire

// ---- hw/tmc_ctl_if.sv ----
// Control links between the top and its commit timer and time base
// Assumes all parties share one clock
`timescale 1ns/1ps
`default_nettype none

interface tmc_ctl_if;
  logic       commit_go;
  logic       commit_done;
  logic       meas_busy;
  logic       auto_req;
  logic [2:0] period;

  modport top      (output commit_go, output meas_busy, output period, input commit_done, input auto_req);
  modport commit   (input commit_go, output commit_done);
  modport timebase (input period, input meas_busy, output auto_req);
endinterface

`default_nettype wire

// ---- hw/tmc_map.svh ----
// Register indices, field positions, reset values and timing figures
// Assumes byte address = 4 * index on a 32-bit Wishbone bus
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define TMC_IDX_W          14
`define TMC_IDX_REF_HI     14'h230A
`define TMC_IDX_REF_LO     14'h230B
`define TMC_IDX_RES_HI     14'h2881
`define TMC_IDX_RES_LO     14'h2882
`define TMC_IDX_CFG        14'h28A0
`define TMC_IDX_START      14'h28B4
`define TMC_IDX_IRQ_STAT   14'h2900
`define TMC_IDX_IRQ_MASK   14'h2901

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMC_CFG_PER_MSB    2
`define TMC_CFG_PER_LSB    0
`define TMC_CFG_BUSY_BIT   3
`define TMC_CFG_BAT_BIT    4
`define TMC_CFG_BSEL_BIT   7
`define TMC_CFG_WR_MASK    8'h97
`define TMC_START_BIT      6
`define TMC_RES_LO_LSB     5
`define TMC_IRQ_MEAS_BIT   0
`define TMC_IRQ_CMT_BIT    1

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define TMC_CFG_RST        8'h00
`define TMC_IRQ_RST        2'h0
`define TMC_RES_RST        11'h000
`define TMC_PER_OFF        3'h0
`define TMC_PER_CONT       3'h7
`define TMC_PER_BASE_EXP   3

// ----------------------------------------
// Timing
// ----------------------------------------
`define TMC_CLK_HZ         10000000
`define TMC_COMMIT_TIME_MS 6
`define TMC_TICK_TIME_S    1

`endif

// ---- hw/tmc_pkg.sv ----
// Types shared by the temperature measurement control modules
// Assumes the map header supplies all numbers
package tmc_pkg;

  // ----------------------------------------
  // Power modes and measurement states
  // ----------------------------------------
  typedef enum logic [1:0] {
    mission_power_mode,
    brownout_power_mode,
    display_only_power_mode,
    sleep_power_mode
  } tmc_power_mode_t;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_TEMP_GO,
    MS_TEMP_WAIT,
    MS_BAT_GO,
    MS_BAT_WAIT
  } tmc_meas_state_t;

  // ----------------------------------------
  // Module state records
  // ----------------------------------------
  typedef struct packed {
    logic            ack;
    logic [7:0]      rdat;
    logic [7:0]      cfg;
    logic [7:0]      cfg_wr;
    logic            pending;
    logic            commit_go;
    logic            oneshot;
    logic [10:0]     result;
    logic [10:0]     ref_val;
    logic            ref_loaded;
    tmc_meas_state_t st;
    logic            start;
    logic            chan;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
    logic            irq;
  } tmc_top_state_t;

endpackage

// ---- hw/tmc_timebase.sv ----
// Second ticks and automatic measurement requests
// Assumes period changes only after a commit
`timescale 1ns/1ps
`default_nettype none
`include "tmc_map.svh"

module tmc_timebase #(
  parameter int TICK_CYCLES = `TMC_TICK_TIME_S * `TMC_CLK_HZ
) (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Control link
  tmc_ctl_if.timebase ctl
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [9:0]    secs;
    logic [2:0]    per_q;
    logic          req;
  } tmc_tb_state_t;

  tmc_tb_state_t s_ff;
  tmc_tb_state_t nxt_s;
  logic [9:0]    lim;

  always_comb
  begin
    nxt_s       = s_ff;
    nxt_s.per_q = ctl.period;
    lim         = 10'h001 << (`TMC_PER_BASE_EXP + ctl.period);
    if (ctl.meas_busy)
      nxt_s.req = 1'b0;
    if (ctl.period != s_ff.per_q || ctl.period == `TMC_PER_OFF)
    begin
      // Restart the interval so a new period counts in full
      nxt_s.pre  = '0;
      nxt_s.secs = '0;
      nxt_s.req  = 1'b0;
    end
    else if (ctl.period == `TMC_PER_CONT)
      nxt_s.req = !ctl.meas_busy;
    else if (s_ff.pre == PW'(TICK_CYCLES - 1))
    begin
      nxt_s.pre = '0;
      if (s_ff.secs == lim - 10'h001)
      begin
        nxt_s.secs = '0;
        nxt_s.req  = 1'b1;
      end
      else
        nxt_s.secs = s_ff.secs + 10'h001;
    end
    else
      nxt_s.pre = s_ff.pre + PW'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // Power mode never gates requests: runs in every mode
  assign ctl.auto_req = s_ff.req;

endmodule // tmc_timebase

`default_nettype wire

// ---- hw/tmc_top.sv ----
// Temperature measurement control: Wishbone registers, sequencer, interrupt
// Assumes sensor handshake and power mode come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "tmc_map.svh"

// Overview of operation
// - 11-bit result split high byte, low three
// - Pending flag set; config writes ignored meanwhile
// - Commit lasts up to six milliseconds
// - Read-only 11-bit reading taken at 22 C
// - Battery measured with each temperature when enabled
// - Source select: 1 main, 0 clock battery
// - Period: off, 2^(3+n) seconds, continuous
// - Automatic measurement in every power mode
// - One-shot request cleared when measurement completes
module tmc_top #(
  parameter int COMMIT_CYCLES = `TMC_COMMIT_TIME_MS * (`TMC_CLK_HZ / 1000),
  parameter int TICK_CYCLES   = `TMC_TICK_TIME_S * `TMC_CLK_HZ
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sensor handshake
  output logic             sensor_start_o,
  output logic             sensor_bat_o,
  output logic             battery_source_select_o,
  input  wire logic        sensor_done_i,
  input  wire logic [10:0] sensor_data_i,
  // Calibration and power
  input  wire logic [10:0] cal_22c_i,
  input  wire logic [1:0]  power_mode_i,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------
  // State and links
  // ----------------------------------------
  tmc_pkg::tmc_top_state_t s_ff;
  tmc_pkg::tmc_top_state_t nxt_s;
  tmc_ctl_if               ctl ();

  logic                    wb_req;
  logic [`TMC_IDX_W-1:0]   idx;
  logic [7:0]              rd;
  logic [1:0]              ev;
  logic                    low_power;
  logic                    os_set;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  tmc_commit #(
    .COMMIT_CYCLES (COMMIT_CYCLES)
  ) u_commit (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (ctl.commit)
  );

  tmc_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (ctl.timebase)
  );

  assign ctl.commit_go = s_ff.commit_go;
  assign ctl.meas_busy = (s_ff.st != tmc_pkg::MS_IDLE);
  assign ctl.period    = s_ff.cfg[`TMC_CFG_PER_MSB:`TMC_CFG_PER_LSB];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_s           = s_ff;
    nxt_s.ack       = 1'b0;
    nxt_s.start     = 1'b0;
    nxt_s.commit_go = 1'b0;
    ev              = 2'h0;
    os_set          = 1'b0;
    wb_req          = wb_cyc_i && wb_stb_i && !s_ff.ack;
    idx             = wb_adr_i[15:2];
    // One-shot is not honoured in the two battery-only display and sleep modes
    low_power       = (power_mode_i == tmc_pkg::display_only_power_mode) ||
                      (power_mode_i == tmc_pkg::sleep_power_mode);

    // Calibration word caught once after reset release
    if (!s_ff.ref_loaded)
    begin
      nxt_s.ref_val    = cal_22c_i;
      nxt_s.ref_loaded = 1'b1;
    end

    // Read mux; unmapped indices read zero
    rd = 8'h00;
    unique case (idx)
      `TMC_IDX_REF_HI:   rd = {5'h00, s_ff.ref_val[10:8]};
      `TMC_IDX_REF_LO:   rd = s_ff.ref_val[7:0];
      `TMC_IDX_RES_HI:   rd = s_ff.result[10:3];
      `TMC_IDX_RES_LO:   rd = {s_ff.result[2:0], 5'h00};
      `TMC_IDX_CFG:
      begin
        rd                    = s_ff.cfg_wr & `TMC_CFG_WR_MASK;
        rd[`TMC_CFG_BUSY_BIT] = s_ff.pending;
      end
      `TMC_IDX_START:    rd = {1'b0, s_ff.oneshot, 6'h00};
      `TMC_IDX_IRQ_STAT: rd = {6'h00, s_ff.irq_stat};
      `TMC_IDX_IRQ_MASK: rd = {6'h00, s_ff.irq_mask};
      default:           rd = 8'h00;
    endcase

    // Bus access; one wait-free ack per request
    if (wb_req)
    begin
      nxt_s.ack  = 1'b1;
      nxt_s.rdat = rd;
      if (wb_we_i && wb_sel_i[0])
      begin
        unique case (idx)
          `TMC_IDX_CFG:
          begin
            // Locked out until the previous commit finishes
            if (!s_ff.pending)
            begin
              nxt_s.cfg_wr    = wb_dat_i[7:0] & `TMC_CFG_WR_MASK;
              nxt_s.pending   = 1'b1;
              nxt_s.commit_go = 1'b1;
            end
          end
          `TMC_IDX_START:
          begin
            if (wb_dat_i[`TMC_START_BIT] && !low_power &&
                ctl.period == `TMC_PER_OFF)
              os_set = 1'b1;
          end
          `TMC_IDX_IRQ_STAT: nxt_s.irq_stat = s_ff.irq_stat & ~wb_dat_i[1:0];
          `TMC_IDX_IRQ_MASK: nxt_s.irq_mask = wb_dat_i[1:0];
          default:           nxt_s.irq_stat = nxt_s.irq_stat;
        endcase
      end
    end

    // Commit completion makes the new byte live
    if (ctl.commit_done)
    begin
      nxt_s.cfg                    = s_ff.cfg_wr;
      nxt_s.pending                = 1'b0;
      ev[`TMC_IRQ_CMT_BIT]         = 1'b1;
    end

    // Measurement sequencer
    unique case (s_ff.st)
      tmc_pkg::MS_IDLE:
      begin
        if (ctl.auto_req || s_ff.oneshot)
          nxt_s.st = tmc_pkg::MS_TEMP_GO;
      end
      tmc_pkg::MS_TEMP_GO:
      begin
        nxt_s.start = 1'b1;
        nxt_s.chan  = 1'b0;
        nxt_s.st    = tmc_pkg::MS_TEMP_WAIT;
      end
      tmc_pkg::MS_TEMP_WAIT:
      begin
        if (sensor_done_i)
        begin
          // Whole word in one edge; the two byte reads can still straddle an update
          nxt_s.result = sensor_data_i;
          if (s_ff.cfg[`TMC_CFG_BAT_BIT])
            nxt_s.st = tmc_pkg::MS_BAT_GO;
          else
          begin
            nxt_s.oneshot         = 1'b0;
            ev[`TMC_IRQ_MEAS_BIT] = 1'b1;
            nxt_s.st              = tmc_pkg::MS_IDLE;
          end
        end
      end
      tmc_pkg::MS_BAT_GO:
      begin
        nxt_s.start = 1'b1;
        nxt_s.chan  = 1'b1;
        nxt_s.st    = tmc_pkg::MS_BAT_WAIT;
      end
      tmc_pkg::MS_BAT_WAIT:
      begin
        if (sensor_done_i)
        begin
          nxt_s.oneshot         = 1'b0;
          ev[`TMC_IRQ_MEAS_BIT] = 1'b1;
          nxt_s.st              = tmc_pkg::MS_IDLE;
        end
      end
      default:
        nxt_s.st = tmc_pkg::MS_IDLE;
    endcase

    // New request on the finishing edge wins over the clear
    if (os_set)
      nxt_s.oneshot = 1'b1;

    // Set after clear so a same-cycle event survives
    nxt_s.irq_stat = nxt_s.irq_stat | ev;
    nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff            <= '0;
      s_ff.cfg        <= `TMC_CFG_RST;
      s_ff.cfg_wr     <= `TMC_CFG_RST;
      s_ff.result     <= `TMC_RES_RST;
      s_ff.irq_stat   <= `TMC_IRQ_RST;
      s_ff.irq_mask   <= `TMC_IRQ_RST;
      s_ff.st         <= tmc_pkg::MS_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o                = {24'h000000, s_ff.rdat};
  assign wb_ack_o                = s_ff.ack;
  assign sensor_start_o          = s_ff.start;
  assign sensor_bat_o            = s_ff.chan;
  assign battery_source_select_o = s_ff.cfg[`TMC_CFG_BSEL_BIT];
  assign irq_o                   = s_ff.irq;

endmodule // tmc_top

`default_nettype wire

// ---- verification/tmc_top_asserts.sv ----
// Port-level checks for the temperature measurement control top
// Assumes bind onto tmc_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module tmc_top_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Sensor
  input wire logic        sensor_start_o,
  input wire logic        sensor_bat_o,
  input wire logic        sensor_done_i
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // ----------------------------------------
  // Read data layout
  // ----------------------------------------
  a_read_width: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  a_res_lo_field: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'hA208 |-> wb_dat_o[4:0] == 5'h00)
    else $error("result low byte has stray bits");
  a_ref_hi_field: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h8C28 |-> wb_dat_o[7:3] == 5'h00)
    else $error("reference high byte has stray bits");

  // ----------------------------------------
  // Sensor sequencing
  // ----------------------------------------
  a_start_pulse: assert property (sensor_start_o |=> !sensor_start_o)
    else $error("start longer than one cycle");
  a_bat_rise: assert property ($rose(sensor_bat_o) |-> sensor_start_o)
    else $error("battery select moved without start");
  a_bat_after_temp: assert property (sensor_start_o && sensor_bat_o |-> $past(sensor_done_i, 2))
    else $error("battery start not two cycles after done");
endmodule // tmc_top_asserts

bind tmc_top tmc_top_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sensor_start_o(sensor_start_o), .sensor_bat_o(sensor_bat_o), .sensor_done_i(sensor_done_i)
);

`default_nettype wire

// ---- verification/tmc_top_tb.sv ----
// Self-checking bench for the temperature measurement control top
// Assumes short commit and tick counts; bench plays bus master and sensor
`timescale 1ns/1ps
`default_nettype none
`include "tmc_map.svh"

module tmc_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int CC = 20;
  localparam int TC = 4;
  logic        clk_i, rst_i, cyc, we, ack, st, bat, bsel, done, irq;
  logic [15:0] adr;
  logic [31:0] dat, rdat, q;
  logic [10:0] sdat;
  logic [1:0]  pm;
  int          fails, n_checks, k;

  tmc_top #(.COMMIT_CYCLES(CC), .TICK_CYCLES(TC)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sensor_start_o(st), .sensor_bat_o(bat), .battery_source_select_o(bsel),
    .sensor_done_i(done), .sensor_data_i(sdat), .cal_22c_i(11'h5A3),
    .power_mode_i(pm), .irq_o(irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Held until ack is sampled; one idle cycle before the next call
  task automatic wb(input logic w, input logic [13:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= {ix, 2'b00};
    dat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask

  task automatic rd(input logic [13:0] ix, input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  task automatic wait_start(input int lim);
    k = 0;
    while (st !== 1'b1 && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic reply(input logic [10:0] v);
    done <= 1'b1;
    sdat <= v;
    @(posedge clk_i);
    done <= 1'b0;
    sdat <= ~v;
  endtask

  // Sensor answers a conversion; no wait when a battery start follows
  task automatic meas(input logic b, input logic [10:0] v, input logic rb);
    wait_start(3000);
    chk(32'(k < 3000), 32'h1);
    chk(32'(bat), 32'(b));
    reply(v);
    if (rb)
    begin
      repeat (3) @(posedge clk_i);
      rd(`TMC_IDX_RES_HI, v[10:3]);
      rd(`TMC_IDX_RES_LO, {v[2:0], 5'h00});
    end
  endtask

  // Software polls pending before any further configuration write
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, `TMC_IDX_CFG, 8'h00);
      n++;
    end
    while (q[3] !== 1'b0 && n < 40);
    chk(32'(q[3]), 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`TMC_IDX_CFG, 8'h00);
    rd(`TMC_IDX_REF_HI, 8'h05);
    wb(1'b1, `TMC_IDX_REF_LO, 8'h11);
    rd(`TMC_IDX_REF_LO, 8'hA3);
    wb(1'b1, 14'h0400, 8'hFF);
    rd(14'h0400, 8'h00);
    rd(`TMC_IDX_IRQ_STAT, 8'h00);
  endtask

  task automatic t_oneshot;
    wb(1'b1, `TMC_IDX_IRQ_MASK, 8'h03);
    wb(1'b1, `TMC_IDX_START, 8'h40);
    meas(1'b0, 11'h6B5, 1'b1);
    rd(`TMC_IDX_START, 8'h00);
    rd(`TMC_IDX_IRQ_STAT, 8'h01);
    chk(32'(irq), 32'h1);
    wb(1'b1, `TMC_IDX_IRQ_STAT, 8'h01);
    rd(`TMC_IDX_IRQ_STAT, 8'h00);
    chk(32'(irq), 32'h0);
    pm <= 2'h3;
    wb(1'b1, `TMC_IDX_START, 8'h40);
    wait_start(40);
    chk(k, 40);
    pm <= 2'h0;
  endtask

  task automatic t_commit;
    realtime t0;
    wb(1'b1, `TMC_IDX_CFG, 8'h90);
    t0 = $realtime;
    rd(`TMC_IDX_CFG, 8'h98);
    wb(1'b1, `TMC_IDX_CFG, 8'h01);
    rd(`TMC_IDX_CFG, 8'h98);
    wait_idle;
    chk(32'(($realtime - t0) / 100.0 <= CC + 8), 32'h1);
    chk(q, 32'h90);
    chk(32'(bsel), 32'h1);
    rd(`TMC_IDX_IRQ_STAT, 8'h02);
    wb(1'b1, `TMC_IDX_IRQ_STAT, 8'h02);
    wb(1'b1, `TMC_IDX_START, 8'h40);
    meas(1'b0, 11'h2C9, 1'b0);
    meas(1'b1, 11'h7FF, 1'b0);
    rd(`TMC_IDX_RES_HI, 8'h59);
    rd(`TMC_IDX_RES_LO, 8'h20);
    wb(1'b1, `TMC_IDX_CFG, 8'h00);
    wait_idle;
    chk(32'(bsel), 32'h0);
  endtask

  task automatic t_period;
    int e;
    for (int n = 1; n <= 7; n++)
    begin
      pm <= 2'(n);
      wb(1'b1, `TMC_IDX_CFG, 8'(n));
      wait_idle;
      e = (8 << n) * TC;
      wait_start(n < 7 ? e + 20 : 40);
      if (n < 7)
        chk(32'(k >= e - 8 && k <= e + 6), 32'h1);
      chk(32'(st), 32'h1);
      reply(11'(n * 'h123));
    end
    wait_start(8);
    chk(32'(st), 32'h1);
    wb(1'b1, `TMC_IDX_CFG, 8'h00);
    wait_idle;
    reply(11'h001);
    wait_start(300);
    chk(k, 300);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Whole run is well under 8000 cycles
  initial
  begin
    #3000000;
    fails++;
    summarize;
  end

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 16'h0000;
    dat = 32'h0;
    done = 1'b0;
    sdat = 11'h000;
    pm = 2'h0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_oneshot;
    t_commit;
    t_period;
    summarize;
  end
endmodule // tmc_top_tb

`default_nettype wire
